// ---- ebd_ctrl.sv ----
// External bus state controller: ordinary, DRAM and multiplexed I/O cycles
//
// Notes on behaviour
// - Wait input is sampled for ordinary accesses with software wait set and for DRAM accesses with two or three waits.
// - Wait pin sampled two cycles before the wait-to-second-state edge.
// - Extension adds lead and trail cycles with chip select only; data held.
// - Address bits 31..24 equal area code selects the DRAM space.
// - Row shift select: 9, 10, 11 or 12 bits.
// - Row phase shifts upper address down; column phase shows bits 21..0.
// - DRAM access: precharge, row, column, fetch; at least four cycles, or column and fetch only (two cycles) on a burst same-row hit.
// - One column strobe per byte lane, only transferred lanes asserted.
// - DMA single-address column cycle also drives read and write strobes.
// - Precharge, row-to-column, read and write wait bits set DRAM waits.
// - External wait extends DRAM access only with two or three waits.
// - Burst enable runs consecutive same-row accesses as fast page.
// - Row-hold mode keeps row strobe low across other space accesses.
// - Counter match triggers CAS-before-RAS refresh and restarts counting.
// - Refresh row width field sets row-strobe cycles in refresh.
// - Refresh mode and enable both set: hold strobes for self-refresh.
// - Bus release in self-refresh keeps only DRAM strobes and read/write.
// - Muxed I/O enable turns chip-select three into address/data space.
// - Address bit 14 picks 8-bit or 16-bit muxed bus.
// - Muxed access: three address cycles with address hold, then data.
// - Muxed space waits behave as ordinary space waits.
// - Self-refresh ignores timer requests and waits for access to finish.
`timescale 1ns/100ps
`default_nettype none
module ebd_ctrl
  import ebd_pkg::*;
#(
  parameter int AW = 22,
  parameter int RW = 8
)(
  input  wire logic           clk_sys,             // System clock
  input  wire logic           rstn,                // Synchronous reset, active low
  input  wire ebd_cfg_t       cfg,                 // Control register bits
  input  wire logic [2:0]     refresh_clock_select,// Refresh count clock
  input  wire logic [RW-1:0]  refresh_constant_reg,// Refresh period
  input  wire ebd_req_t       req,                 // Access request
  input  wire logic           bus_request,         // External release request
  input  wire logic [31:0]    data_in,             // Data pins input
  input  wire logic           wait_n,              // External wait pin
  output logic                req_ready,           // Request taken pulse
  output logic                rdata_valid,         // Read data pulse
  output logic [31:0]         rdata,               // Read data
  output logic [RW-1:0]       refresh_counter,     // Counter value
  output logic                refresh_match,       // Compare match pulse
  output logic [AW-1:0]       addr_out,            // Address pins
  output logic                addr_oe,             // Address pins driven
  output logic [31:0]         data_out,            // Data pins output
  output logic                data_oe,             // Data pins driven
  output logic [EBD_CS_COUNT-1:0] chip_select_n,   // Chip selects, low active
  output logic                read_n,              // Read strobe, low active
  output logic [3:0]          byte_write_strobes_n,// Write strobes, low active
  output logic                row_strobe_n,        // Row strobe, low active
  output logic [3:0]          column_strobes_n,    // Column strobes, low active
  output logic                read_write_line,     // High for read
  output logic                address_hold_strobe_n,// Muxed address hold
  output logic                bus_granted,         // Bus released
  output logic                self_refresh_active  // In self-refresh
);
  ebd_state_t state;
  ebd_state_t next_state;
  ebd_req_t   cur;
  logic [1:0] wcnt;
  logic [1:0] phase_cnt;
  logic       wait_s;
  logic       refresh_pend;
  logic       row_open;
  logic [23:0] open_row_addr;
  logic       start_dram;
  logic       start_mux;
  logic       is_dram;
  logic       is_mux;
  logic       same_row;
  logic [3:0] row_shift;
  logic [AW-1:0] row_addr;
  logic [AW-1:0] col_addr;
  logic [AW-1:0] row_keep;
  logic       cur_mux;
  logic       keep_row;
  logic [1:0] dram_wait;
  logic       ext_dram_ok;
  logic       self_req;
  logic       timer_match;
  logic [RW-1:0] cnt_w;

  ebd_sync u_wait_sync
  (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       (wait_n),
    .q       (wait_s)
  );

  ebd_refresh_timer #(.CW(RW)) u_timer
  (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .clk_sel  (refresh_clock_select),
    .constant (refresh_constant_reg),
    .count    (cnt_w),
    .match    (timer_match)
  );

  assign is_dram = req.addr[EBD_AREA_HI:EBD_AREA_LO] == EBD_DRAM_AREA;
  assign is_mux  = cfg.muxed_io_enable_bit && req.cs == 2'(EBD_MUX_CS) && !is_dram;
  assign row_shift = 4'(EBD_ROW_SHIFT_MIN) +
                     {2'b00, cfg.row_shift_select_hi, cfg.row_shift_select_lo};
  // Upper pins keep their own bits while the row lands on the low pins
  assign row_keep = AW'({AW{1'b1}} << (EBD_ROW_TOP + 1 - row_shift));
  assign row_addr = (cur.addr[AW-1:0] & row_keep) |
                    AW'(cur.addr[EBD_ROW_TOP:0] >> row_shift);
  assign col_addr = cur.addr[AW-1:0];
  assign same_row = row_open && ((open_row_addr >> row_shift)
                    == (req.addr[EBD_ROW_TOP:0] >> row_shift));
  assign dram_wait = cur.write ? cfg.dram_write_wait : cfg.dram_read_wait;
  assign ext_dram_ok = dram_wait >= 2'(EBD_MIN_EXT_WAIT);
  assign self_req = cfg.refresh_enable_bit && cfg.refresh_mode_bit;
  assign cur_mux = cfg.muxed_io_enable_bit && cur.cs == 2'(EBD_MUX_CS) &&
                   cur.addr[EBD_AREA_HI:EBD_AREA_LO] != EBD_DRAM_AREA;
  // Open row is let go before any refresh so the strobes start precharged
  assign keep_row = row_open && !refresh_pend && !self_req;

  always_comb
  begin
    next_state = state;
    case (state)
      EBD_IDLE:
        if (self_req)
          next_state = row_open ? EBD_RHOLD : EBD_SELF;
        else if (refresh_pend)
          next_state = EBD_CBR1;
        else if (req.valid && is_dram)
          next_state = (same_row && cfg.burst_enable_bit) ? EBD_COL : EBD_PRE;
        else if (req.valid && is_mux)
          next_state = EBD_MADDR;
        else if (req.valid)
          next_state = (cfg.select_extend_bits[req.cs] != 1'b0) ? EBD_LEAD : EBD_ORD1;
      EBD_MADDR:
        if (phase_cnt == 2'(EBD_MUX_ADDR_CYC - 1))
          next_state = cfg.select_extend_bits[cur.cs] ? EBD_LEAD : EBD_ORD1;
      EBD_LEAD:  next_state = EBD_ORD1;
      EBD_ORD1:  next_state = (cfg.wait_control_reg != 2'h0) ? EBD_OWAIT : EBD_ORD2;
      EBD_OWAIT:
        // Synchroniser delay puts the pin sample two cycles ahead of this move
        if (wcnt == 2'h0 && wait_s)
          next_state = EBD_ORD2;
      EBD_ORD2:
        next_state = cfg.select_extend_bits[cur.cs] ? EBD_TRAIL : EBD_IDLE;
      EBD_TRAIL: next_state = EBD_IDLE;
      EBD_PRE:
        if (phase_cnt == {1'b0, cfg.precharge_time_bit})
          next_state = EBD_ROW;
      EBD_ROW:   next_state = cfg.row_to_column_delay_bit ? EBD_RCD : EBD_COL;
      EBD_RCD:   next_state = EBD_COL;
      EBD_COL:   next_state = (dram_wait != 2'h0) ? EBD_DWAIT : EBD_FETCH;
      EBD_DWAIT:
        if (wcnt == 2'h0 && (!ext_dram_ok || wait_s))
          next_state = EBD_FETCH;
      EBD_FETCH:
        // Row stays open when burst is enabled; closed on the next miss
        next_state = EBD_IDLE;
      EBD_RHOLD: next_state = EBD_SELF;
      EBD_CBR1:  next_state = EBD_CBR2;
      EBD_CBR2:
        if (phase_cnt == {cfg.refresh_row_width_hi, cfg.refresh_row_width_lo})
          next_state = EBD_IDLE;
      EBD_SELF:  if (!self_req) next_state = EBD_IDLE;
      default:   next_state = EBD_IDLE;
    endcase
  end

  assign start_dram = state == EBD_IDLE && next_state inside {EBD_PRE, EBD_COL};
  assign start_mux  = state == EBD_IDLE && next_state inside {EBD_MADDR, EBD_LEAD, EBD_ORD1};

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state         <= EBD_IDLE;
      cur           <= '0;
      wcnt          <= 2'h0;
      phase_cnt     <= 2'h0;
      refresh_pend  <= 1'b0;
      row_open      <= 1'b0;
      open_row_addr <= 24'h000000;
    end
    else
    begin
      state <= next_state;
      if (start_dram || start_mux)
        cur <= req;
      phase_cnt <= (next_state != state) ? 2'h0 : phase_cnt + 2'h1;
      if (next_state == EBD_OWAIT && state != EBD_OWAIT)
        wcnt <= cfg.wait_control_reg - 2'h1;
      else if (next_state == EBD_DWAIT && state != EBD_DWAIT)
        wcnt <= dram_wait - 2'h1;
      else if (wcnt != 2'h0)
        wcnt <= wcnt - 2'h1;
      // Timer match during self-refresh is dropped; set wins over clear
      if (timer_match && cfg.refresh_enable_bit && !cfg.refresh_mode_bit)
        refresh_pend <= 1'b1;
      else if (state == EBD_CBR1)
        refresh_pend <= 1'b0;
      if (state == EBD_ROW)
        begin
          row_open      <= cfg.burst_enable_bit;
          open_row_addr <= cur.addr[EBD_ROW_TOP:0];
        end
      else if (state == EBD_IDLE && req.valid && is_dram && !same_row)
        row_open <= 1'b0;
      else if (state == EBD_IDLE && req.valid && !is_dram && !cfg.row_hold_mode_bit)
        row_open <= 1'b0;
      else if (state inside {EBD_CBR1, EBD_RHOLD})
        row_open <= 1'b0;
    end
  end

  // Registered pin drive
  logic in_ord, in_cs, in_dram_row, in_cas, rd_phase, in_self;
  assign in_ord  = state inside {EBD_ORD1, EBD_OWAIT, EBD_ORD2};
  assign in_cs   = in_ord || state inside {EBD_LEAD, EBD_TRAIL, EBD_MADDR};
  assign in_cas  = state inside {EBD_COL, EBD_DWAIT, EBD_FETCH};
  assign in_dram_row = state inside {EBD_ROW, EBD_RCD} || in_cas;
  assign rd_phase = in_ord && !cur.write;
  assign in_self = state == EBD_SELF;

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      addr_out              <= '0;
      addr_oe               <= 1'b0;
      data_out              <= 32'h00000000;
      data_oe               <= 1'b0;
      chip_select_n         <= '1;
      read_n                <= 1'b1;
      byte_write_strobes_n  <= 4'hF;
      row_strobe_n          <= 1'b1;
      column_strobes_n      <= 4'hF;
      read_write_line       <= 1'b1;
      address_hold_strobe_n <= 1'b1;
      bus_granted           <= 1'b0;
      self_refresh_active   <= 1'b0;
      req_ready             <= 1'b0;
      rdata_valid           <= 1'b0;
      rdata                 <= 32'h00000000;
      refresh_counter       <= '0;
      refresh_match         <= 1'b0;
    end
    else
    begin
      refresh_counter <= cnt_w;
      refresh_match   <= timer_match;
      req_ready   <= start_dram || start_mux;
      rdata_valid <= (state == EBD_ORD2 || state == EBD_FETCH) && !cur.write;
      rdata       <= !cur_mux ? data_in
                     : cur.addr[EBD_WIDTH_BIT] ? {16'h0000, data_in[15:0]}
                     : {24'h000000, data_in[7:0]};
      bus_granted <= bus_request && (state == EBD_IDLE || in_self);
      self_refresh_active <= in_self;
      addr_oe  <= !(bus_request && in_self);
      addr_out <= state inside {EBD_ROW, EBD_RCD, EBD_PRE} ? row_addr : col_addr;
      // Muxed space carries the address on the data pins first
      data_oe  <= state == EBD_MADDR || (cur.write && (in_cs || in_cas));
      data_out <= (state == EBD_MADDR) ? cur.addr : cur.wdata;
      chip_select_n <= '1;
      if (in_cs)
        chip_select_n[cur.cs] <= 1'b0;
      read_n <= !(rd_phase || (cur.dma_single && state == EBD_COL && !cur.write));
      byte_write_strobes_n <= (in_ord && cur.write) ||
                              (cur.dma_single && state == EBD_COL && cur.write)
                              ? ~cur.lanes : 4'hF;
      address_hold_strobe_n <= state != EBD_MADDR;
      // Row strobe also held through row-hold and refresh tails
      row_strobe_n <= !(in_dram_row || keep_row ||
                        state == EBD_CBR2 || in_self);
      column_strobes_n <= in_cas ? ~cur.lanes
                        : (state inside {EBD_CBR1, EBD_CBR2} || in_self) ? 4'h0 : 4'hF;
      read_write_line <= !(cur.write && (in_cas || state inside {EBD_ROW, EBD_RCD}));
    end
  end
endmodule
`default_nettype wire

// ---- ebd_pkg.sv ----
// Shared constants and carrier types for the external bus DRAM controller
package ebd_pkg;
  localparam logic [7:0] EBD_DRAM_AREA     = 8'h01;
  localparam int         EBD_AREA_HI       = 31;
  localparam int         EBD_AREA_LO       = 24;
  localparam int         EBD_ROW_TOP       = 23;
  localparam int         EBD_ADDR_PINS     = 22;
  localparam int         EBD_ROW_SHIFT_MIN = 9;
  localparam int         EBD_MUX_ADDR_CYC  = 3;
  localparam int         EBD_WIDTH_BIT     = 14;
  localparam int         EBD_MIN_EXT_WAIT  = 2;
  localparam int         EBD_REFRESH_ROW_BASE = 1;
  localparam int         EBD_CS_COUNT      = 4;
  localparam int         EBD_MUX_CS        = 3;

  typedef enum logic [4:0] {
    EBD_IDLE  = 5'h00,
    EBD_LEAD  = 5'h01,
    EBD_ORD1  = 5'h02,
    EBD_OWAIT = 5'h03,
    EBD_ORD2  = 5'h04,
    EBD_TRAIL = 5'h05,
    EBD_MADDR = 5'h06,
    EBD_PRE   = 5'h07,
    EBD_ROW   = 5'h08,
    EBD_RCD   = 5'h09,
    EBD_COL   = 5'h0A,
    EBD_DWAIT = 5'h0B,
    EBD_FETCH = 5'h0C,
    EBD_RHOLD = 5'h0D,
    EBD_CBR1  = 5'h0E,
    EBD_CBR2  = 5'h0F,
    EBD_SELF  = 5'h10
  } ebd_state_t;

  // Configuration bits gathered from the control registers
  typedef struct packed {
    logic [1:0] wait_control_reg;
    logic [3:0] select_extend_bits;
    logic       muxed_io_enable_bit;
    logic       row_shift_select_hi;
    logic       row_shift_select_lo;
    logic       precharge_time_bit;
    logic       row_to_column_delay_bit;
    logic [1:0] dram_write_wait;
    logic [1:0] dram_read_wait;
    logic       burst_enable_bit;
    logic       row_hold_mode_bit;
    logic       refresh_mode_bit;
    logic       refresh_enable_bit;
    logic       refresh_row_width_hi;
    logic       refresh_row_width_lo;
  } ebd_cfg_t;

  // Access request from the internal bus masters
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        dma_single;
    logic [1:0]  cs;
    logic [31:0] addr;
    logic [3:0]  lanes;
    logic [31:0] wdata;
  } ebd_req_t;
endpackage

// ---- ebd_sync.sv ----
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module ebd_sync
  import ebd_pkg::*;
#(
  parameter logic INIT = 1'b1
)(
  input  wire logic clk_sys, // System clock
  input  wire logic rstn,    // Synchronous reset, active low
  input  wire logic d,       // Asynchronous level
  output logic      q        // Synchronised level
);
  logic meta;

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      meta <= INIT;
      q    <= INIT;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- ebd_refresh_timer.sv ----
// Refresh interval counter with compare match and clock prescaler
`timescale 1ns/100ps
`default_nettype none
module ebd_refresh_timer
  import ebd_pkg::*;
#(
  parameter int CW = 8
)(
  input  wire logic          clk_sys,   // System clock
  input  wire logic          rstn,      // Synchronous reset, active low
  input  wire logic [2:0]    clk_sel,   // Count clock select, zero stops
  input  wire logic [CW-1:0] constant,  // Compare value
  output logic [CW-1:0]      count,     // Current count
  output logic               match      // One-cycle compare match pulse
);
  logic [11:0] prescale;
  logic        tick;
  logic [3:0]  tap;

  // Divider ratios 2,8,32,128,512,2048,4096
  assign tap = (clk_sel == 3'h7) ? 4'hB : 4'(2 * clk_sel - 2);
  assign tick = (clk_sel != 3'h0) &&
                ((clk_sel == 3'h7) ? (prescale == 12'hFFF)
                                   : (prescale[tap] && (prescale & ((12'h002 << tap) - 12'h001))
                                      == (12'h001 << tap)));

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      prescale <= 12'h000;
      count    <= '0;
      match    <= 1'b0;
    end
    else
    begin
      prescale <= prescale + 12'h001;
      match    <= 1'b0;
      if (tick)
      begin
        if (count + 1'b1 == constant)
        begin
          count <= '0;
          match <= 1'b1;
        end
        else
          count <= count + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- ebd_ctrl_checker.sv ----
// Port-level assertions for the external bus controller
`timescale 1ns/100ps
`default_nettype none
module ebd_ctrl_checker
  import ebd_pkg::*;
(
  input wire logic                    clk_sys,               // System clock
  input wire logic                    rstn,                  // Reset, active low
  input wire ebd_cfg_t                cfg,                   // Config bits
  input wire logic                    refresh_match,         // Match pulse
  input wire logic [EBD_CS_COUNT-1:0] chip_select_n,         // Chip selects
  input wire logic                    read_n,                // Read strobe
  input wire logic [3:0]              byte_write_strobes_n,  // Write strobes
  input wire logic                    row_strobe_n,          // Row strobe
  input wire logic [3:0]              column_strobes_n,      // Column strobes
  input wire logic                    address_hold_strobe_n, // Address hold
  input wire logic                    addr_oe,               // Address driven
  input wire logic                    data_oe,               // Data driven
  input wire logic                    bus_granted,           // Bus released
  input wire logic                    self_refresh_active    // Self-refresh
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_ord_len;
    $fell(read_n) && row_strobe_n && cfg.wait_control_reg == 2'h0 |-> ##1 !read_n ##1 read_n;
  endproperty
  a_ord_len: assert property (p_ord_len) else $error("read strobe length wrong");

  property p_rd_cs;
    !read_n && row_strobe_n |-> chip_select_n != 4'hF;
  endproperty
  a_rd_cs: assert property (p_rd_cs) else $error("read strobe outside select");

  property p_ras_cs;
    $fell(row_strobe_n) |-> chip_select_n == 4'hF;
  endproperty
  a_ras_cs: assert property (p_ras_cs) else $error("select with row strobe");

  property p_ah_strb;
    !address_hold_strobe_n |-> read_n && (&byte_write_strobes_n);
  endproperty
  a_ah_strb: assert property (p_ah_strb) else $error("strobe in address phase");

  property p_ah_len;
    $fell(address_hold_strobe_n) |-> !address_hold_strobe_n[*3] ##1 address_hold_strobe_n;
  endproperty
  a_ah_len: assert property (p_ah_len) else $error("address phase length wrong");

  property p_cbr;
    refresh_match && cfg.refresh_enable_bit && !cfg.refresh_mode_bit
      |-> ##[1:40] column_strobes_n == 4'h0;
  endproperty
  a_cbr: assert property (p_cbr) else $error("no refresh after match");

  property p_self;
    self_refresh_active[*3] |-> !row_strobe_n && column_strobes_n == 4'h0;
  endproperty
  a_self: assert property (p_self) else $error("self-refresh strobes high");

  property p_self_rel;
    self_refresh_active && bus_granted
      |-> !addr_oe && !data_oe && chip_select_n == 4'hF && !row_strobe_n;
  endproperty
  a_self_rel: assert property (p_self_rel) else $error("bus not released right");
endmodule

bind ebd_ctrl ebd_ctrl_checker u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .cfg(cfg), .refresh_match(refresh_match),
  .chip_select_n(chip_select_n), .read_n(read_n), .byte_write_strobes_n(byte_write_strobes_n),
  .row_strobe_n(row_strobe_n), .column_strobes_n(column_strobes_n),
  .address_hold_strobe_n(address_hold_strobe_n), .addr_oe(addr_oe), .data_oe(data_oe),
  .bus_granted(bus_granted), .self_refresh_active(self_refresh_active)
);
`default_nettype wire

// ---- ebd_mem_model.sv ----
// Behavioural model of the external memories and their wait source
`timescale 1ns/100ps
`default_nettype none
module ebd_mem_model
  import ebd_pkg::*;
#(
  parameter logic [31:0] DATA = 32'hC3A5_5A3C
)(
  input  wire logic       clk_sys,              // System clock
  input  wire logic       read_n,               // Read strobe
  input  wire logic [3:0] byte_write_strobes_n, // Write strobes
  input  wire logic [3:0] column_strobes_n,     // Column strobes
  input  wire logic       read_write_line,      // High for read
  input  wire logic [3:0] wait_len,             // Wait cycles to request
  output logic [31:0]     data_in,              // Data pins to the block
  output var logic        wait_n                // Wait pin, pulled up
);
  logic        rd_on;
  logic        acc_on;
  logic [3:0]  held;
  logic [31:0] alt;
  assign rd_on   = !read_n || (column_strobes_n != 4'hF && read_write_line);
  assign acc_on  = rd_on || byte_write_strobes_n != 4'hF;
  // Released bus toggles so a stale value never looks valid
  assign data_in = rd_on ? DATA : alt;
  // Wait follows the strobes at once, as a slow device drives it
  assign wait_n  = !(acc_on && held < wait_len);
  initial {held, alt} = {4'h0, ~DATA};
  always @(posedge clk_sys)
  begin
    alt  <= ~alt;
    held <= !acc_on ? 4'h0 : (held == 4'hF) ? held : held + 4'h1;
  end
endmodule
`default_nettype wire

// ---- external_bus_dram_controller_tb.sv ----
// Self-checking testbench for the external bus controller
`timescale 1ns/100ps
`default_nettype none
module external_bus_dram_controller_tb;
  import ebd_pkg::*;
  localparam logic [31:0] MD = 32'hC3A5_5A3C;
  logic clk_sys, rstn, bus_request, req_ready, rdata_valid, refresh_match, addr_oe, data_oe;
  logic read_n, row_strobe_n, read_write_line, address_hold_strobe_n, bus_granted, self_on, wait_n;
  logic [2:0] clk_sel;
  logic [3:0] wait_len, chip_select_n, byte_write_strobes_n, column_strobes_n;
  logic [7:0] rconst, refresh_counter;
  logic [21:0] addr_out, row_a, col_a;
  logic [31:0] data_in, rdata, data_out, rv;
  logic [3:0] cas_v;
  ebd_cfg_t cfg;
  ebd_req_t req;
  int fail_count, cmp_count, cyc, cs_lo, rd_lo, wr_lo, ah_lo, cas_lo, ras_lo, c0, c1, r0, r1;
  bit row_seen, col_seen, dma_seen, rseen;

  ebd_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .cfg(cfg), .refresh_clock_select(clk_sel),
    .refresh_constant_reg(rconst), .req(req), .bus_request(bus_request), .data_in(data_in),
    .wait_n(wait_n), .req_ready(req_ready), .rdata_valid(rdata_valid), .rdata(rdata),
    .refresh_counter(refresh_counter), .refresh_match(refresh_match), .addr_out(addr_out),
    .addr_oe(addr_oe), .data_out(data_out), .data_oe(data_oe), .chip_select_n(chip_select_n),
    .read_n(read_n), .byte_write_strobes_n(byte_write_strobes_n), .row_strobe_n(row_strobe_n),
    .column_strobes_n(column_strobes_n), .read_write_line(read_write_line),
    .address_hold_strobe_n(address_hold_strobe_n), .bus_granted(bus_granted),
    .self_refresh_active(self_on));
  ebd_mem_model #(.DATA(MD)) mem (.clk_sys(clk_sys), .read_n(read_n),
    .byte_write_strobes_n(byte_write_strobes_n), .column_strobes_n(column_strobes_n),
    .read_write_line(read_write_line), .wait_len(wait_len), .data_in(data_in), .wait_n(wait_n));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Sampled on the falling edge, clear of the launching edge
  always @(negedge clk_sys)
  begin
    cs_lo += (chip_select_n != 4'hF); rd_lo += !read_n; ah_lo += !address_hold_strobe_n;
    wr_lo += (byte_write_strobes_n != 4'hF); cas_lo += (column_strobes_n != 4'hF);
    ras_lo += !row_strobe_n;
    if (!row_strobe_n && !row_seen) {row_seen, row_a} = {1'b1, addr_out};
    if (column_strobes_n != 4'hF && !col_seen)
      {col_seen, col_a, cas_v} = {1'b1, addr_out, column_strobes_n};
    if (column_strobes_n != 4'hF && (!read_n || byte_write_strobes_n != 4'hF)) dma_seen = 1;
    if (rdata_valid === 1'b1) {rseen, rv} = {1'b1, rdata};
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000) begin fail_count++; print_verdict(); end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic clr();
    {cs_lo, rd_lo, wr_lo, ah_lo, cas_lo, ras_lo} = '0;
    {row_seen, col_seen, dma_seen, rseen} = '0;
  endtask

  task automatic acc(input logic wr, input logic dma, input logic [1:0] cs,
                     input logic [31:0] a, input logic [3:0] ln);
    int n;
    clr();
    req <= '{valid:1'b1, write:wr, dma_single:dma, cs:cs, addr:a, lanes:ln, wdata:32'h1234_5678};
    n = 0;
    do @(posedge clk_sys); while (req_ready !== 1'b1 && ++n < 80);
    chk("req_ready", req_ready, 1'b1);
    req.valid <= 1'b0;
    repeat (40) @(posedge clk_sys);
  endtask

  task automatic t_ordinary();
    acc(0, 0, 2'h0, 32'h0000_0100, 4'hF);
    chk("ord_rdata", rv, MD);
    chk("ord_len", rd_lo, 2);
    cfg.wait_control_reg <= 2'h3; wait_len <= 4'h0;
    acc(0, 0, 2'h0, 32'h0000_0100, 4'hF); c0 = rd_lo;
    wait_len <= 4'h4;
    acc(0, 0, 2'h0, 32'h0000_0100, 4'hF);
    chk("ext_wait", rd_lo > c0, 1'b1);
    cfg.select_extend_bits <= 4'hF; cfg.wait_control_reg <= 2'h0;
    acc(1, 0, 2'h1, 32'h0000_0200, 4'hF);
    chk("ext_cs", cs_lo, wr_lo + 2);
    cfg.select_extend_bits <= 4'h0;
  endtask

  task automatic t_dram();
    logic [31:0] a;
    int s;
    a = 32'h01AB_CDEC;
    for (int m = 0; m < 4; m++)
    begin
      {cfg.row_shift_select_hi, cfg.row_shift_select_lo} <= m[1:0];
      acc(0, 0, 2'h0, a, 4'h3);
      s = 9 + m;
      chk("row_addr", row_a, (a[21:0] & (22'h3FFFFF << (24 - s))) | 22'(a[23:0] >> s));
      chk("col_addr", col_a, a[21:0]);
      chk("lanes", cas_v, 4'hC);
      chk("dram_cs", cs_lo, 0);
      chk("dram_rdata", rv, MD);
      r0 = ras_lo;
    end
    for (int w = 1; w < 4; w += 2)
    begin
      cfg.dram_read_wait <= 2'(w); wait_len <= 4'h0;
      acc(0, 0, 2'h0, a, 4'hF); c0 = cas_lo;
      wait_len <= 4'h4;
      acc(0, 0, 2'h0, a, 4'hF);
      chk("dram_ext", cas_lo > c0, w == 3);
    end
    {cfg.dram_read_wait, wait_len, cfg.row_to_column_delay_bit} <= {2'h0, 4'h0, 1'b1};
    acc(0, 0, 2'h0, a, 4'hF);
    chk("rcd", ras_lo > r0, 1'b1);
    cfg.row_to_column_delay_bit <= 1'b0;
    acc(1, 1, 2'h0, a, 4'hF);
    chk("dma_strobes", dma_seen, 1'b1);
  endtask

  task automatic t_muxed();
    cfg.muxed_io_enable_bit <= 1'b1;
    acc(0, 0, 2'h3, 32'h0000_4000, 4'h3);
    chk("addr_phase", ah_lo, EBD_MUX_ADDR_CYC);
    chk("mux16", rv, {16'h0000, MD[15:0]});
    acc(0, 0, 2'h3, 32'h0000_0010, 4'h1);
    chk("mux8", rv, {24'h00_0000, MD[7:0]});
    cfg.muxed_io_enable_bit <= 1'b0;
  endtask

  task automatic t_refresh();
    {clk_sel, rconst, cfg.refresh_enable_bit} <= {3'h1, 8'h04, 1'b1};
    for (int w = 0; w < 4; w += 3)
    begin
      {cfg.refresh_row_width_hi, cfg.refresh_row_width_lo} <= w[1:0];
      repeat (2) @(posedge clk_sys);
      c0 = 0;
      do @(posedge clk_sys); while (refresh_match !== 1'b1 && ++c0 < 200);
      chk("match", refresh_match, 1'b1);
      clr();
      repeat (12) @(posedge clk_sys);
      if (w == 0) r0 = ras_lo;
    end
    chk("ras_width", ras_lo > r0, 1'b1);
    clk_sel <= 3'h0;
    cfg.refresh_mode_bit <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk("self", {self_on, row_strobe_n, column_strobes_n}, 6'h20);
    bus_request <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk("release", {bus_granted, addr_oe, row_strobe_n}, 3'h4);
    bus_request <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    {rstn, bus_request, clk_sel, rconst, wait_len, cfg, req} = '0;
    {fail_count, cmp_count, cyc} = '0;
    clr();
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk("idle", {chip_select_n, row_strobe_n, read_n}, 6'h3F);
    wait_len <= 4'h3;
    t_ordinary();
    t_dram();
    t_muxed();
    t_refresh();
    print_verdict();
  end
endmodule
`default_nettype wire
